// [src/qhb_ctrl.sv]
// quad half-bridge control: register slave on ahb-lite, interlock, chopping, protection
`default_nettype none
module qhb_ctrl
   import qhb_pkg::*;
#(
   parameter int NUM_BRIDGES = 4 // four half-bridges, two fets each
)(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // ahb-lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // analog front end
   input wire logic chop_frequency_input_i,
   input wire qhb_sense_t [NUM_BRIDGES-1:0] sense_i,
   input wire logic low_voltage_i,
   input wire logic high_voltage_i,
   input wire logic overtemp_warn_i,
   input wire logic overtemp_limit_i,
   input wire logic overtemp_reset_en_i,
   // power stage
   output qhb_drive_t [NUM_BRIDGES-1:0] bridge_outputs_o,
   output logic [2:0] current_limit_select_o,
   output logic sense_gain_select_o,
   output logic recirculation_detect_out_o,
   output logic overtemp_reset_o
);
   // elaboration check: register layout fixes four bridges
   if (NUM_BRIDGES != 4)
   begin : g_bad_count
      $error("qhb_ctrl serves exactly four bridges");
   end

   // bus timing in brief:
   // - the slave never stalls, so hreadyout_o stays high
   // - an address phase is taken when hsel, hready and a
   //   non-idle transfer meet at a rising edge
   // - read data is registered at that edge, so it stands
   //   through the whole data phase without a wait state
   // - write data is applied at the edge ending the data
   //   phase, so a read issued right behind a write to the
   //   same register sees the old value; masters must leave
   //   one idle cycle between them
   // - only bits 7..0 of each word carry state, the rest
   //   read zero and are ignored on write
   // - transfer size is not checked: every access is taken
   //   as a whole word, narrower accesses hit the same word

   // register state
   // - the output word is plain storage; the control word drops bits 5..3
   // - the enable bit is the only bit of its word that
   //   this block keeps; the other system bits live elsewhere
   // - the status flags are set by hardware and cleared by
   //   writing a one; a zero write never touches them
   // - set always beats clear, so an event in the clearing
   //   cycle is never lost
   logic [7:0] out_bits_q; // bridge_output_bits
   logic [7:0] ctl_bits_q; // bridge_control_bits
   logic power_stage_enable_q; // system_control_reg bit 7
   logic ocf_q; // bridge_overcurrent_flag
   logic lvf_q; // low_voltage_flag
   logic hvf_q; // high_voltage_flag
   logic htf_q; // overtemp_warning_flag
   // ahb data-phase capture
   logic wr_pend_q;
   logic [9:0] wr_addr_q;

   // address phase decode
   wire logic addr_phase = hsel_i & hready_i & htrans_i[1];
   wire logic rd_take = addr_phase & ~hwrite_i;
   wire logic wr_take = addr_phase & hwrite_i;
   wire logic [9:0] word_addr = {haddr_i[9:2], 2'b00};

   // write strobes in the data phase
   wire logic wr_out = wr_pend_q & (wr_addr_q == QHB_ADDR_OUT);
   wire logic wr_ctl = wr_pend_q & (wr_addr_q == QHB_ADDR_CTL);
   wire logic wr_sys = wr_pend_q & (wr_addr_q == QHB_ADDR_SYS);
   wire logic wr_stat = wr_pend_q & (wr_addr_q == QHB_ADDR_STAT);
   wire logic wr_ifr = wr_pend_q & (wr_addr_q == QHB_ADDR_IFR);

   // one-to-clear strobes; zero writes leave flags alone
   wire logic clr_ocf = wr_stat & hwdata_i[QHB_STAT_OCF];
   wire logic clr_lvf = wr_ifr & hwdata_i[QHB_IFR_LVF];
   wire logic clr_hvf = wr_ifr & hwdata_i[QHB_IFR_HVF];
   wire logic clr_htf = wr_ifr & hwdata_i[QHB_IFR_HTF];

   // status images
   wire logic [7:0] stat_img = {4'h0, lvf_q, hvf_q, ocf_q, htf_q};
   wire logic [7:0] ifr_img = {4'h0, lvf_q, hvf_q, 1'b0, htf_q};
   wire logic [7:0] sys_img = {power_stage_enable_q, 7'h00};

   // read mux, unmapped words read zero
   wire logic [7:0] rd_byte =
      (word_addr == QHB_ADDR_OUT) ? out_bits_q :
      (word_addr == QHB_ADDR_CTL) ? ctl_bits_q :
      (word_addr == QHB_ADDR_SYS) ? sys_img :
      (word_addr == QHB_ADDR_STAT) ? stat_img :
      (word_addr == QHB_ADDR_IFR) ? ifr_img : 8'h00;

   // bus slave: zero wait states, always okay
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 10'h000;
         hrdata_o <= 32'h0000_0000;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end
      else
      begin
         wr_pend_q <= wr_take;
         wr_addr_q <= word_addr;
         // read data registered in the address phase so it stands in the data phase
         if (rd_take)
         begin
            hrdata_o <= {24'h000000, rd_byte};
         end
      end
   end

   // software registers
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         out_bits_q <= QHB_RST_OUT;
         ctl_bits_q <= QHB_RST_CTL;
         power_stage_enable_q <= QHB_RST_SYS[QHB_SYS_PSE];
      end
      else
      begin
         if (wr_out)
         begin
            out_bits_q <= hwdata_i[7:0];
         end
         if (wr_ctl)
         begin
            ctl_bits_q <= hwdata_i[7:0] & QHB_CTL_MASK;
         end
         if (wr_sys)
         begin
            power_stage_enable_q <= hwdata_i[QHB_SYS_PSE];
         end
      end
   end

   // chop input edge handling
   // - the pin is taken as already synchronous to the clock,
   //   so a single history flop is enough for edge detection
   // - history resets low, the idle level of the pin, so no
   //   false rising edge appears right after reset
   // - both edges are one-cycle pulses; each bridge picks
   //   the edge that re-arms its low side
   // - a chop rate far above the recommended range still
   //   works logically but leaves the load little on-time
   // chop input edge detect; input is taken as synchronous, one stage for history
   logic chop_q;
   wire logic chop_rise = chop_frequency_input_i & ~chop_q;
   wire logic chop_fall = ~chop_frequency_input_i & chop_q;
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         chop_q <= 1'b0;
      end
      else
      begin
         chop_q <= chop_frequency_input_i;
      end
   end

   // protection event detection across all bridges
   logic [NUM_BRIDGES-1:0] hs_oc_vec;
   logic [NUM_BRIDGES-1:0] ls_oc_vec;
   logic [NUM_BRIDGES-1:0] recirc_vec;
   wire logic oc_event = (|hs_oc_vec) | (|ls_oc_vec);
   logic hs_kill_q; // all high sides held off
   logic ls_kill_q; // all low sides held off

   // protection flags
   // - overcurrent on any high side kills all high sides,
   //   on any low side all low sides; both raise one flag
   // - the kill latches share the flag's clear, so writing
   //   a one re-enables both sides together
   // - the voltage flags are set again by their inputs every cycle,
   //   so a clear while the condition persists is useless
   // - the overtemperature warning is report-only here; the
   //   shutdown goes through the system reset instead
   // flags: a set in the clearing cycle wins
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ocf_q <= 1'b0;
         hs_kill_q <= 1'b0;
         ls_kill_q <= 1'b0;
         lvf_q <= 1'b0;
         hvf_q <= 1'b0;
         htf_q <= 1'b0;
      end
      else
      begin
         ocf_q <= oc_event | (ocf_q & ~clr_ocf);
         hs_kill_q <= (|hs_oc_vec) | (hs_kill_q & ~clr_ocf);
         ls_kill_q <= (|ls_oc_vec) | (ls_kill_q & ~clr_ocf);
         lvf_q <= low_voltage_i | (lvf_q & ~clr_lvf);
         hvf_q <= high_voltage_i | (hvf_q & ~clr_hvf);
         htf_q <= overtemp_warn_i | (htf_q & ~clr_htf);
      end
   end

   // global gate: enable on, no voltage flag
   wire logic stage_ok = power_stage_enable_q & ~lvf_q & ~hvf_q;

   // per-bridge drive
   // - high side has priority when both request bits are set
   // - a fet turns on only after its partner's gate reports
   //   discharged, which costs a cycle or two on a swap; the
   //   delay is accepted to rule out shoot-through
   // - a fet that is already on stays on while requested,
   //   so gate-sense glitches cannot chop a conducting fet
   // - the current limit trips only a conducting low side and
   //   holds it off until the chosen chop edge re-arms it
   // - overcurrent sensing is qualified by the fet being on,
   //   so a comparator idling high cannot set the flag
   // per-bridge drive logic
   logic [NUM_BRIDGES-1:0] ls_trip_q; // low side chopped off by limit
   qhb_drive_t [NUM_BRIDGES-1:0] drive_q;
   for (genvar b = 0; b < NUM_BRIDGES; b++)
   begin : g_bridge
      wire logic hs_bit = out_bits_q[2*b+1];
      wire logic ls_bit = out_bits_q[2*b];
      // staggered chopping: upper pair re-arms on the falling edge
      wire logic rearm = (ctl_bits_q[QHB_CTL_STAG] && b >= 2) ? chop_fall : chop_rise;
      // requested state after priority and protection
      wire logic hs_req = stage_ok & hs_bit & ~hs_kill_q;
      wire logic ls_req = stage_ok & ls_bit & ~hs_bit & ~ls_kill_q & ~ls_trip_q[b];
      assign hs_oc_vec[b] = sense_i[b].hs_overcur & drive_q[b].hs_on;
      assign ls_oc_vec[b] = sense_i[b].ls_overcur & drive_q[b].ls_on;
      assign recirc_vec[b] = sense_i[b].recirc;

      // current limit trip, cleared by re-arm edge
      always_ff @(posedge core_clk_i or posedge rst_i)
      begin
         if (rst_i)
         begin
            ls_trip_q[b] <= 1'b0;
         end
         else if (drive_q[b].ls_on && sense_i[b].ls_limit)
         begin
            ls_trip_q[b] <= 1'b1;
         end
         else if (rearm)
         begin
            ls_trip_q[b] <= 1'b0;
         end
      end

      // break-before-make: turn on only once the partner gate is discharged
      always_ff @(posedge core_clk_i or posedge rst_i)
      begin
         if (rst_i)
         begin
            drive_q[b] <= '0;
         end
         else
         begin
            drive_q[b].hs_on <= hs_req & (drive_q[b].hs_on | (~drive_q[b].ls_on &
               sense_i[b].ls_gate_low));
            drive_q[b].ls_on <= ls_req & ~(sense_i[b].ls_limit & drive_q[b].ls_on) &
               (drive_q[b].ls_on | (~drive_q[b].hs_on & sense_i[b].hs_gate_low));
         end
      end
   end

   // analog side outputs
   // - limit select and gain select copy the control word so
   //   that the comparators see a registered, glitch-free code
   // - codes 0 to 2 of the limit select mean no limit; the
   //   comparator side decodes them, not this block
   // - recirculation is a plain registered or of all bridges,
   //   one cycle behind the sense lines
   // - the overtemperature reset request is registered too
   // analog settings, recirculation and overtemp outputs
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         current_limit_select_o <= 3'h0;
         sense_gain_select_o <= 1'b0;
         recirculation_detect_out_o <= 1'b0;
         overtemp_reset_o <= 1'b0;
      end
      else
      begin
         current_limit_select_o <= ctl_bits_q[2:0];
         sense_gain_select_o <= ctl_bits_q[QHB_CTL_GAIN];
         recirculation_detect_out_o <= |recirc_vec;
         overtemp_reset_o <= overtemp_reset_en_i & overtemp_limit_i;
      end
   end

   // overtemp reset: the chip reset that follows clears every register
   // limitation: if the system does not route overtemp_reset_o into
   // rst_i, the outputs stay as software left them
   // drive word leaves the block straight from its flops
   assign bridge_outputs_o = drive_q;
endmodule : qhb_ctrl
`default_nettype wire

// [inc/qhb_pkg.sv]
// package for the quad half-bridge control block: register map, fields, reset values
`default_nettype none
package qhb_pkg;
   // register byte offsets (printed offsets are not multiples of four: index * 4)
   localparam logic [7:0] QHB_IDX_OUT = 8'h01; // bridge_output_bits index
   localparam logic [7:0] QHB_IDX_CTL = 8'h02; // bridge_control_bits index
   localparam logic [7:0] QHB_IDX_SYS = 8'h03; // system_control_reg index
   localparam logic [7:0] QHB_IDX_STAT = 8'h0c; // system_status_reg index
   localparam logic [7:0] QHB_IDX_IFR = 8'h0d; // interrupt_flag_reg index (chosen)
   localparam logic [9:0] QHB_ADDR_OUT = {QHB_IDX_OUT, 2'b00};
   localparam logic [9:0] QHB_ADDR_CTL = {QHB_IDX_CTL, 2'b00};
   localparam logic [9:0] QHB_ADDR_SYS = {QHB_IDX_SYS, 2'b00};
   localparam logic [9:0] QHB_ADDR_STAT = {QHB_IDX_STAT, 2'b00};
   localparam logic [9:0] QHB_ADDR_IFR = {QHB_IDX_IFR, 2'b00};
   // field positions
   localparam int QHB_CTL_STAG = 7; // staggered_chop_enable
   localparam int QHB_CTL_GAIN = 6; // sense_gain_select
   localparam int QHB_SYS_PSE = 7; // power_stage_enable
   localparam int QHB_STAT_LVF = 3; // low_voltage_flag copy
   localparam int QHB_STAT_HVF = 2; // high_voltage_flag copy
   localparam int QHB_STAT_OCF = 1; // bridge_overcurrent_flag
   localparam int QHB_STAT_HTF = 0; // overtemp_warning_flag copy
   localparam int QHB_IFR_LVF = 3; // low_voltage_flag
   localparam int QHB_IFR_HVF = 2; // high_voltage_flag
   localparam int QHB_IFR_HTF = 0; // overtemp_warning_flag
   // reset values
   localparam logic [7:0] QHB_RST_OUT = 8'h00;
   localparam logic [7:0] QHB_RST_CTL = 8'h00;
   localparam logic [7:0] QHB_RST_SYS = 8'h00;
   localparam logic [7:0] QHB_CTL_MASK = 8'hc7; // bits 5..3 read zero
   localparam logic [7:0] QHB_SYS_MASK = 8'h80; // only the enable bit exists here
   // ahb constants
   localparam logic [1:0] QHB_HTRANS_NONSEQ = 2'b10;
   localparam logic [2:0] QHB_HSIZE_WORD = 3'b010;
   // analog sense inputs of one half-bridge
   typedef struct packed {
      logic hs_gate_low; // high-side gate discharged below threshold
      logic ls_gate_low; // low-side gate discharged below threshold
      logic hs_overcur; // high-side overcurrent comparator
      logic ls_overcur; // low-side overcurrent comparator
      logic ls_limit; // low-side current above selected limit
      logic recirc; // recirculation current seen
   } qhb_sense_t;
   // drive pair of one half-bridge
   typedef struct packed {
      logic hs_on;
      logic ls_on;
   } qhb_drive_t;
endpackage : qhb_pkg
`default_nettype wire

// [sim/qhb_ctrl_properties.sv]
// assertion checker for the quad half-bridge control block
`default_nettype none
module qhb_ctrl_properties
   import qhb_pkg::*;
#(
   parameter int NUM_BRIDGES = 4 // bridge count, as in the block
)(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // watched inputs
   input wire qhb_sense_t [NUM_BRIDGES-1:0] sense_i,
   input wire logic low_voltage_i,
   input wire logic high_voltage_i,
   input wire logic overtemp_limit_i,
   input wire logic overtemp_reset_en_i,
   // watched outputs
   input wire qhb_drive_t [NUM_BRIDGES-1:0] bridge_outputs_o,
   input wire logic recirculation_detect_out_o,
   input wire logic overtemp_reset_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   localparam logic [2*NUM_BRIDGES-1:0] HS_M = {NUM_BRIDGES{2'b10}}; // high-side bit mask
   wire logic [2*NUM_BRIDGES-1:0] drv = bridge_outputs_o; // flat drive word
   logic hs_hit; // overcurrent only counts on a conducting fet
   logic ls_hit;
   logic any_rec; // recirculation seen anywhere
   // fold the per-bridge sense lines
   always_comb
   begin
      hs_hit = 1'b0;
      ls_hit = 1'b0;
      any_rec = 1'b0;
      for (int b = 0; b < NUM_BRIDGES; b++)
      begin
         hs_hit = hs_hit | (sense_i[b].hs_overcur & bridge_outputs_o[b].hs_on);
         ls_hit = ls_hit | (sense_i[b].ls_overcur & bridge_outputs_o[b].ls_on);
         any_rec = any_rec | sense_i[b].recirc;
      end
   end
   no_shoot_through_a: assert property ((drv & (drv >> 1) & ~HS_M) == '0)
      else $error("both fets of one bridge on");
   hs_bbm_a: assert property ($rose(bridge_outputs_o[0].hs_on) |-> $past(sense_i[0].ls_gate_low))
      else $error("high side on before partner gate low");
   ls_bbm_a: assert property ($rose(bridge_outputs_o[0].ls_on) |-> $past(sense_i[0].hs_gate_low))
      else $error("low side on before partner gate low");
   hs_oc_off_a: assert property (hs_hit |-> ##[1:3] (drv & HS_M) == '0)
      else $error("high sides not off after overcurrent");
   ls_oc_off_a: assert property (ls_hit |-> ##[1:3] (drv & ~HS_M) == '0)
      else $error("low sides not off after overcurrent");
   volt_off_a: assert property (low_voltage_i || high_voltage_i |-> ##[1:3] drv == '0)
      else $error("outputs on under voltage fault");
   recirc_follow_a: assert property (1'b1 |=> recirculation_detect_out_o == $past(any_rec))
      else $error("recirculation output wrong");
   ot_reset_a: assert property (overtemp_limit_i && overtemp_reset_en_i |=> overtemp_reset_o)
      else $error("no overtemperature reset");
   limit_chop_a: assert property (sense_i[0].ls_limit && bridge_outputs_o[0].ls_on
      |-> ##[1:2] !bridge_outputs_o[0].ls_on)
      else $error("low side kept on over limit");
   cover property (hs_hit);
   cover property (ls_hit);
   cover property ($rose(recirculation_detect_out_o));
   cover property (overtemp_reset_o);
endmodule : qhb_ctrl_properties
bind qhb_ctrl qhb_ctrl_properties #(.NUM_BRIDGES(NUM_BRIDGES)) u_props (.core_clk_i, .rst_i,
   .sense_i, .low_voltage_i, .high_voltage_i, .overtemp_limit_i, .overtemp_reset_en_i,
   .bridge_outputs_o, .recirculation_detect_out_o, .overtemp_reset_o);
`default_nettype wire

// [sim/qhb_bridge_model.sv]
// behavioural model of the four power half-bridges behind the block
`default_nettype none
module qhb_bridge_model
   import qhb_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // gate drive from the block
   input wire qhb_drive_t [3:0] drive_i,
   // fault injection from the bench, one bit per bridge
   input wire logic [3:0] hs_oc_i,
   input wire logic [3:0] ls_oc_i,
   input wire logic [3:0] lim_i,
   input wire logic [3:0] recirc_i,
   // sense lines back to the block
   output var qhb_sense_t [3:0] sense_o
);
   logic [3:0] hs_low_q; // high-side gate discharged
   logic [3:0] ls_low_q; // low-side gate discharged
   // gates need a cycle to discharge, so a released fet still blocks its partner once
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         hs_low_q <= 4'hf;
         ls_low_q <= 4'hf;
      end
      else
      begin
         for (int b = 0; b < 4; b++)
         begin
            hs_low_q[b] <= !drive_i[b].hs_on;
            ls_low_q[b] <= !drive_i[b].ls_on;
         end
      end
   end
   // comparators only see current through a conducting fet
   always_comb
   begin
      for (int b = 0; b < 4; b++)
      begin
         sense_o[b] = {hs_low_q[b], ls_low_q[b], hs_oc_i[b] & drive_i[b].hs_on,
            ls_oc_i[b] & drive_i[b].ls_on, lim_i[b] & drive_i[b].ls_on, recirc_i[b]};
      end
   end
endmodule : qhb_bridge_model
`default_nettype wire

// [sim/qhb_ctrl_tb_top.sv]
// self-checking testbench for the quad half-bridge control block
`default_nettype none
module qhb_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import qhb_pkg::*;
   // bus and pin stimulus
   logic core_clk_i = 0, rst_i = 1, hsel_i = 1, hwrite_i = 0, chop_i = 0;
   logic lv = 0, hv = 0, otw = 0, otl = 0, oten = 0;
   logic [1:0] htrans_i = 0;
   logic [2:0] hsize_i = QHB_HSIZE_WORD;
   logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, rd;
   logic hreadyout_o, hresp_o, rec_o, otr_o, gain_o;
   logic [2:0] cls_o;
   qhb_drive_t [3:0] drv_o;
   qhb_sense_t [3:0] sense;
   logic [3:0] hs_oc = 0, ls_oc = 0, lim = 0, rc = 0; // fault injection
   int failures = 0, n_compared = 0, cycles = 0;
   int m_out = 0, m_ctl = 0, m_sys = 0; // register model
   logic [9:0] amap [6] = '{QHB_ADDR_OUT, QHB_ADDR_CTL, QHB_ADDR_SYS, QHB_ADDR_STAT,
      QHB_ADDR_IFR, 10'h3fc};
   always #10 core_clk_i = ~core_clk_i;
   qhb_ctrl #(.NUM_BRIDGES(4)) dut (.core_clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i,
      .hwrite_i, .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o,
      .hresp_o, .chop_frequency_input_i(chop_i), .sense_i(sense), .low_voltage_i(lv),
      .high_voltage_i(hv), .overtemp_warn_i(otw), .overtemp_limit_i(otl),
      .overtemp_reset_en_i(oten), .bridge_outputs_o(drv_o), .current_limit_select_o(cls_o),
      .sense_gain_select_o(gain_o), .recirculation_detect_out_o(rec_o),
      .overtemp_reset_o(otr_o));
   qhb_bridge_model u_fets (.core_clk_i, .rst_i, .drive_i(drv_o), .hs_oc_i(hs_oc),
      .ls_oc_i(ls_oc), .lim_i(lim), .recirc_i(rc), .sense_o(sense));
   // verdict and end of run
   task automatic final_report;
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : final_report
   // hang guard
   always @(posedge core_clk_i)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         failures++;
         $display("CHECK FAILED at %0t: timeout", $time);
         final_report();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one single ahb transfer, then an idle cycle so a read never trails its write
   task automatic bus(input logic w, input logic [9:0] a, input int d);
      haddr_i <= {22'h0, a};
      hwrite_i <= w;
      htrans_i <= QHB_HTRANS_NONSEQ;
      do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
      htrans_i <= 2'h0;
      hwdata_i <= {24'h0, d[7:0]};
      do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
      rd = hrdata_o;
      @(posedge core_clk_i);
   endtask : bus
   task automatic settle;
      repeat (5) @(posedge core_clk_i);
   endtask : settle
   // expected fet drive from the register model
   function automatic logic [7:0] exp_drv();
      logic [7:0] e;
      for (int b = 0; b < 4; b++)
      begin
         e[2*b+1] = m_out[2*b+1];
         e[2*b] = m_out[2*b] & !m_out[2*b+1];
      end
      return m_sys[7] ? e : 8'h0;
   endfunction : exp_drv
   initial
   begin
      void'($urandom(52193));
      repeat (6) @(posedge core_clk_i);
      rst_i <= 1'b0;
      @(posedge core_clk_i);
      foreach (amap[i])
      begin
         bus(0, amap[i], 0);
         chk(rd, 0);
      end
      chk(hresp_o, 0);
      $display("reset values done");
      for (int i = 0; i < 8; i++)
      begin
         m_ctl = ($urandom() & 8'hf8) | i;
         bus(1, QHB_ADDR_CTL, m_ctl);
         bus(0, QHB_ADDR_CTL, 0);
         chk(rd, m_ctl & 8'hc7);
         chk(cls_o, i);
         chk(gain_o, m_ctl[6]);
      end
      $display("control register done");
      m_sys = 8'h80;
      bus(1, QHB_ADDR_SYS, m_sys);
      repeat (12)
      begin
         m_out = $urandom_range(255);
         bus(1, QHB_ADDR_OUT, m_out);
         settle();
         chk(drv_o, exp_drv());
         bus(0, QHB_ADDR_OUT, 0);
         chk(rd, m_out);
      end
      m_sys = 0;
      bus(1, QHB_ADDR_SYS, m_sys);
      settle();
      chk(drv_o, 0);
      m_sys = 8'h80;
      bus(1, QHB_ADDR_SYS, m_sys);
      $display("drive control done");
      for (int k = 0; k < 2; k++)
      begin
         m_out = k ? 8'h55 : 8'haa;
         bus(1, QHB_ADDR_OUT, m_out);
         settle();
         {hs_oc, ls_oc} <= k ? 8'h01 : 8'h40;
         @(posedge core_clk_i);
         {hs_oc, ls_oc} <= 8'h0;
         settle();
         chk(drv_o, 0);
         bus(1, QHB_ADDR_STAT, 0);
         bus(0, QHB_ADDR_STAT, 0);
         chk(rd[QHB_STAT_OCF], 1);
         bus(1, QHB_ADDR_STAT, 8'h02);
         bus(0, QHB_ADDR_STAT, 0);
         chk(rd[QHB_STAT_OCF], 0);
         settle();
         chk(drv_o, exp_drv());
      end
      $display("overcurrent done");
      for (int k = 0; k < 2; k++)
      begin
         {lv, hv} <= k ? 2'b01 : 2'b10;
         settle();
         chk(drv_o, 0);
         bus(1, QHB_ADDR_IFR, 8'h0c);
         bus(0, QHB_ADDR_IFR, 0);
         chk(rd[3-k], 1);
         {lv, hv} <= 2'b00;
         bus(1, QHB_ADDR_IFR, 8'h0c);
         settle();
         chk(drv_o, exp_drv());
      end
      $display("voltage faults done");
      for (int k = 0; k < 2; k++)
      begin
         m_ctl = k ? 8'h87 : 8'h07;
         bus(1, QHB_ADDR_CTL, m_ctl);
         lim <= 4'hf;
         @(posedge core_clk_i);
         lim <= 4'h0;
         settle();
         chk(drv_o, 0);
         repeat (1250) @(posedge core_clk_i);
         chop_i <= 1'b1;
         settle();
         chk(drv_o, k ? 8'h05 : 8'h55);
         repeat (1250) @(posedge core_clk_i);
         chop_i <= 1'b0;
         settle();
         chk(drv_o, 8'h55);
      end
      $display("chopping done");
      repeat (8)
      begin
         rc <= $urandom_range(15);
         settle();
         chk(rec_o, |rc);
      end
      otw <= 1'b1;
      @(posedge core_clk_i);
      otw <= 1'b0;
      bus(0, QHB_ADDR_IFR, 0);
      chk(rd[QHB_IFR_HTF], 1);
      {otl, oten} <= 2'b11;
      settle();
      chk(otr_o, 1);
      $display("recirculation and temperature done");
      final_report();
   end
endmodule : qhb_ctrl_tb_top
`default_nettype wire
